/* File: hw/eeprom_link_if.sv */
/*
  two-wire link between the host end and the eeprom end.
  assumes a pull-up: the data line is low whenever any end enables a low.
*/
`timescale 1ns/10ps
interface eeprom_link_if;
  logic scl;          // bus clock, driven by the host
  logic host_sda_o;   // host data out (always low)
  logic host_sda_oe;  // host pulls the data line
  logic dev_sda_o;    // device data out (always low)
  logic dev_sda_oe;   // device pulls the data line
  logic sda;          // resolved open-drain level

  // ****************************************************************
  // wired-and with pull-up
  // ****************************************************************
  assign sda = ~(host_sda_oe & ~host_sda_o) & ~(dev_sda_oe & ~dev_sda_o);

  modport host   (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : eeprom_link_if

/* File: hw/eeprom_rd_device.sv */
/*
  eeprom end of the two-wire link: address match, word counter, byte
  receive and the read path with sequential streaming.
  assumes a free-running link clock much faster than the bus clock, used
  to oversample the bus lines; the bus lines are asynchronous to it.
*/
`timescale 1ns/10ps
// Overview of operation
// - read starts like write, direction bit high
// - counter holds last accessed address plus one
// - counter survives stop and new start
// - read increment wraps whole array to zero
// - write increment wraps within current page
// - matched read address: shift byte at counter
// - host ends read with nack then stop
// - random read: dummy write loads the counter
// - repeated start, read address, ack, byte out
// - host acks each byte to continue reading
// - each sent byte advances counter, ack brings next byte out
// - address byte: prefix, select bits, direction
// - eight-bit bytes, ack low on ninth clock
// - mismatched address: no ack, back to standby
// - stop returns device to standby
module eeprom_rd_device (
  input  wire logic            LINK_CLK_I,              // oversampling link clock
  input  wire logic            SYS_RST_I,               // async reset, high
  eeprom_link_if.device        link,                    // two-wire bus
  input  wire logic            CHIP_SELECT_PIN_HIGH_I,  // strap, top select bit
  input  wire logic            CHIP_SELECT_PIN_MID_I,   // strap, middle select bit
  input  wire logic            CHIP_SELECT_PIN_LOW_I,   // strap, low select bit
  output logic                 DEV_ACTIVE_O,            // transaction in progress
  output logic [7:0]           DEV_WORD_ADDR_O          // word address counter
);
  // ****************************************************************
  // state types
  // ****************************************************************
  typedef enum logic [2:0] {
    D_IDLE,     // standby
    D_RX,       // shifting a byte in
    D_ACK,      // driving our ack
    D_TX,       // shifting a byte out
    D_HACK      // host ack slot
  } dstate_t;

  typedef enum logic [1:0] {
    PH_DEV,     // device address byte
    PH_WORD,    // word address byte
    PH_DATA     // write data byte
  } phase_t;

  typedef struct packed {
    dstate_t     st;      // bus state
    phase_t      ph;      // which byte is being received
    logic [3:0]  cnt;     // bit counter
    logic [7:0]  sh;      // shift register
    logic [7:0]  ctr;     // word address counter
    logic        oe;      // pulling the data line
    logic        rd;      // direction bit of last address byte
    logic        hack;    // host acked last byte
    logic        busy;    // registered activity flag
    logic [2:0]  scl_s;   // scl sync and edge history
    logic [2:0]  sda_s;   // sda sync and edge history
    logic [2:0]  sel_m;   // strap sync, first stage
    logic [2:0]  sel_q;   // strap sync, second stage
  } dev_s_t;

  localparam int MEM_DEPTH_C = eeprom_rd_pkg::MEM_DEPTH;  // array depth
  dev_s_t      q;          // registered state
  dev_s_t      n;          // next state
  logic [7:0]  mem [MEM_DEPTH_C];  // storage array
  logic [7:0]  rd_byte;    // byte at the counter
  logic        mem_we;     // write strobe for the array
  logic        scl_hi;     // synchronised scl level
  logic        sda_lv;     // synchronised sda level
  logic        scl_rise;   // scl rising edge
  logic        scl_fall;   // scl falling edge
  logic        start_c;    // start condition seen
  logic        stop_c;     // stop condition seen
  logic        addr_hit;   // address byte matches us

  // ****************************************************************
  // helpers
  // ****************************************************************
  // load a byte for shifting out, msb on the line right away
  function automatic dev_s_t load_tx(input dev_s_t s, input logic [7:0] b);
    dev_s_t r;
    r     = s;
    r.st  = D_TX;
    r.sh  = {b[6:0], 1'b0};
    r.oe  = ~b[7];
    r.cnt = 4'h1;
    return r;
  endfunction : load_tx

  // ****************************************************************
  // bus event decode
  // ****************************************************************
  // stage 0 of each sync chain feeds only stage 1
  assign scl_hi   = q.scl_s[1];
  assign sda_lv   = q.sda_s[1];
  assign scl_rise = q.scl_s[1] & ~q.scl_s[2];
  assign scl_fall = ~q.scl_s[1] & q.scl_s[2];
  // data may only move while scl is low, so a change with scl high
  // steady over two samples is a start or a stop
  assign start_c  = scl_hi & q.scl_s[2] & ~sda_lv & q.sda_s[2];
  assign stop_c   = scl_hi & q.scl_s[2] & sda_lv & ~q.sda_s[2];
  assign addr_hit = (q.sh[7:4] == eeprom_rd_pkg::DEV_PREFIX) && (q.sh[3:1] == q.sel_q);
  assign rd_byte  = mem[q.ctr];

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n       = q;
    mem_we  = 1'b0;
    n.scl_s = {q.scl_s[1:0], link.scl};
    n.sda_s = {q.sda_s[1:0], link.sda};
    n.sel_m = {CHIP_SELECT_PIN_HIGH_I, CHIP_SELECT_PIN_MID_I, CHIP_SELECT_PIN_LOW_I};
    n.sel_q = q.sel_m;
    if (start_c) begin
      // start or repeated start; counter kept, nothing programmed
      n.st  = D_RX;
      n.ph  = PH_DEV;
      n.cnt = 4'h0;
      n.oe  = 1'b0;
    end else if (stop_c) begin
      // back to standby, counter kept
      n.st  = D_IDLE;
      n.oe  = 1'b0;
    end else begin
      case (q.st)
        D_IDLE: begin
          n.oe = 1'b0;  // quiet until a start
        end
        D_RX: begin
          // sample on the rising edge, decide after the eighth bit
          if (scl_rise && q.cnt < eeprom_rd_pkg::BYTE_BITS) begin
            n.sh  = {q.sh[6:0], sda_lv};
            n.cnt = q.cnt + 4'h1;
          end
          if (scl_fall && q.cnt == eeprom_rd_pkg::BYTE_BITS) begin
            n.st = D_ACK;
            n.oe = 1'b1;
            case (q.ph)
              PH_DEV: begin
                n.rd = q.sh[0];
                if (!addr_hit) begin
                  n.st = D_IDLE;
                  n.oe = 1'b0;
                end
              end
              PH_WORD: begin
                n.ctr = q.sh;
              end
              default: begin
                // data byte: store, advance inside the page
                mem_we = 1'b1;
                n.ctr  = {q.ctr[7:3], 3'(q.ctr[2:0] + 3'h1)};
              end
            endcase
          end
        end
        D_ACK: begin
          // release after the ninth clock, then send or receive
          if (scl_fall) begin
            n.oe  = 1'b0;
            n.cnt = 4'h0;
            if (q.ph == PH_DEV && q.rd) begin
              n = load_tx(n, rd_byte);
            end else begin
              n.st = D_RX;
              n.ph = (q.ph == PH_DEV) ? PH_WORD : PH_DATA;
            end
          end
        end
        D_TX: begin
          // next bit on each falling edge
          if (scl_fall) begin
            if (q.cnt == eeprom_rd_pkg::BYTE_BITS) begin
              n.oe  = 1'b0;
              n.st  = D_HACK;
              n.ctr = q.ctr + 8'h01;
            end else begin
              n.oe  = ~q.sh[7];
              n.sh  = {q.sh[6:0], 1'b0};
              n.cnt = q.cnt + 4'h1;
            end
          end
        end
        D_HACK: begin
          // host low in the ninth clock asks for one more byte
          if (scl_rise) begin
            n.hack = ~sda_lv;
          end
          if (scl_fall) begin
            if (q.hack) begin
              n = load_tx(n, rd_byte);
            end else begin
              n.st = D_IDLE;
            end
          end
        end
        default: begin
          n.st = D_IDLE;
          n.oe = 1'b0;
        end
      endcase
    end
    n.busy = (n.st != D_IDLE);
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge LINK_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      q       <= '0;
      // idle bus sits high, so edge history starts high: no false edge
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // storage array
  // ****************************************************************
  // no reset: contents are not defined at power-up
  always_ff @(posedge LINK_CLK_I) begin
    if (mem_we) begin
      mem[q.ctr] <= q.sh;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign link.dev_sda_o  = 1'b0;   // open drain, only ever pulls low
  assign link.dev_sda_oe = q.oe;
  assign DEV_ACTIVE_O    = q.busy;
  assign DEV_WORD_ADDR_O = q.ctr;
endmodule : eeprom_rd_device

/* File: hw/eeprom_rd_host.sv */
/*
  host end of the two-wire link: makes scl by dividing the core clock and
  runs current reads, random reads and byte writes.
  assumes one eeprom on the bus; returned data arrives asynchronously.
*/
`timescale 1ns/10ps
module eeprom_rd_host (
  input  wire logic                  CORE_CLK_I,   // core clock
  input  wire logic                  SYS_RST_I,    // async reset, high
  eeprom_link_if.host                link,         // two-wire bus
  input  wire logic                  REQ_VALID_I,  // request offered
  output logic                       REQ_READY_O,  // engine idle
  input  wire eeprom_rd_pkg::op_t    REQ_OP_I,     // operation
  input  wire logic [2:0]            REQ_SEL_I,    // target select bits
  input  wire logic [7:0]            REQ_ADDR_I,   // word address
  input  wire logic [7:0]            REQ_WDATA_I,  // write data
  input  wire logic [7:0]            REQ_LEN_I,    // bytes to read, 0 as 1
  output logic [7:0]                 RD_DATA_O,    // received byte
  output logic                       RD_VALID_O,   // byte pulse
  output logic                       DONE_O,       // end pulse
  output logic                       NACK_O        // last op saw a nack
);
  // ****************************************************************
  // state types
  // ****************************************************************
  typedef enum logic [3:0] {
    H_IDLE, H_START, H_DEVW, H_WORD, H_WDATA,
    H_RESTART, H_DEVR, H_RDATA, H_STOP
  } hstate_t;

  typedef struct packed {
    hstate_t             st;      // sequence state
    logic [1:0]          ph;      // quarter of the bus clock
    logic [3:0]          div;     // quarter divider
    logic [3:0]          bitn;    // bit within byte, 8 is ack
    logic [7:0]          sh;      // shift register
    logic [7:0]          left;    // bytes still to read
    eeprom_rd_pkg::op_t  op;      // latched operation
    logic [2:0]          sel;     // latched select bits
    logic [7:0]          addr;    // latched word address
    logic [7:0]          wdata;   // latched write data
    logic                scl;     // bus clock out
    logic                oe;      // pulling the data line
    logic [1:0]          sda_s;   // data line sync
    logic                miss;    // ack slot was high
    logic [7:0]          rdata;   // received byte
    logic                rvalid;  // byte pulse
    logic                done;    // end pulse
    logic                nack;    // sticky until next request
  } host_s_t;

  host_s_t  q;     // registered state
  host_s_t  n;     // next state
  logic     tick;  // quarter boundary
  logic     tx;    // host sends this byte
  logic     sda;   // synchronised data line

  assign tick = (q.div == 4'h0);
  assign tx   = (q.st != H_RDATA);
  assign sda  = q.sda_s[1];

  // ****************************************************************
  // sequencer, one step per quarter of scl
  // ****************************************************************
  always_comb begin
    n        = q;
    n.rvalid = 1'b0;
    n.done   = 1'b0;
    n.sda_s  = {q.sda_s[0], link.sda};
    n.div    = tick ? eeprom_rd_pkg::QTR_CYC - 4'h1 : q.div - 4'h1;
    case (q.st)
      H_IDLE: begin
        n.scl = 1'b1;
        n.oe  = 1'b0;
        if (REQ_VALID_I) begin
          n.st    = H_START;
          n.ph    = 2'h0;
          n.div   = eeprom_rd_pkg::QTR_CYC - 4'h1;
          n.op    = REQ_OP_I;
          n.sel   = REQ_SEL_I;
          n.addr  = REQ_ADDR_I;
          n.wdata = REQ_WDATA_I;
          n.left  = (REQ_LEN_I == 8'h00) ? 8'h01 : REQ_LEN_I;
          n.nack  = 1'b0;
        end
      end
      H_START, H_RESTART: begin
        // release, scl high, pull data low, scl low
        if (tick) begin
          n.ph = q.ph + 2'h1;
          case (q.ph)
            2'h0:    n.oe  = 1'b0;
            2'h1:    n.scl = 1'b1;
            2'h2:    n.oe  = 1'b1;
            default: begin
              n.scl  = 1'b0;
              n.bitn = 4'h0;
              if (q.st == H_START && q.op != eeprom_rd_pkg::OP_CUR_READ) begin
                n.st = H_DEVW;
                n.sh = eeprom_rd_pkg::dev_byte(q.sel, 1'b0);
              end else begin
                n.st = H_DEVR;
                n.sh = eeprom_rd_pkg::dev_byte(q.sel, 1'b1);
              end
            end
          endcase
        end
      end
      H_STOP: begin
        // data low, scl high, release data, done
        if (tick) begin
          n.ph = q.ph + 2'h1;
          case (q.ph)
            2'h0:    n.oe  = 1'b1;
            2'h1:    n.scl = 1'b1;
            2'h2:    n.oe  = 1'b0;
            default: begin
              n.st   = H_IDLE;
              n.done = 1'b1;
            end
          endcase
        end
      end
      default: begin
        // byte states: 8 data bits then the ack slot
        if (tick) begin
          n.ph = q.ph + 2'h1;
          case (q.ph)
            2'h0: begin
              if (q.bitn < eeprom_rd_pkg::BYTE_BITS) n.oe = tx & ~q.sh[7];
              else                                   n.oe = ~tx & (q.left != 8'h01);
            end
            2'h1: n.scl = 1'b1;
            2'h2: begin
              if (q.bitn < eeprom_rd_pkg::BYTE_BITS) begin
                if (!tx) n.sh = {q.sh[6:0], sda};
              end else begin
                n.miss = sda;
              end
            end
            default: begin
              n.scl  = 1'b0;
              n.bitn = q.bitn + 4'h1;
              if (tx && q.bitn < eeprom_rd_pkg::BYTE_BITS) n.sh = {q.sh[6:0], 1'b0};
              if (q.bitn == eeprom_rd_pkg::BYTE_BITS) begin
                n.bitn = 4'h0;
                if (tx && q.miss) begin
                  n.st   = H_STOP;
                  n.nack = 1'b1;
                end else begin
                  case (q.st)
                    H_DEVW: begin
                      n.st = H_WORD;
                      n.sh = q.addr;
                    end
                    H_WORD: begin
                      // restart right after the word address for reads
                      if (q.op == eeprom_rd_pkg::OP_BYTE_WRITE) begin
                        n.st = H_WDATA;
                        n.sh = q.wdata;
                      end else begin
                        n.st = H_RESTART;
                      end
                    end
                    H_DEVR:  n.st = H_RDATA;
                    H_RDATA: begin
                      n.rdata  = q.sh;
                      n.rvalid = 1'b1;
                      n.left   = q.left - 8'h01;
                      if (q.left == 8'h01) n.st = H_STOP;
                    end
                    default: n.st = H_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      q     <= '0;
      q.scl <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign link.scl         = q.scl;
  assign link.host_sda_o  = 1'b0;
  assign link.host_sda_oe = q.oe;
  assign REQ_READY_O      = (q.st == H_IDLE);
  assign RD_DATA_O        = q.rdata;
  assign RD_VALID_O       = q.rvalid;
  assign DONE_O           = q.done;
  assign NACK_O           = q.nack;
endmodule : eeprom_rd_host

/* File: hw/eeprom_rd_pkg.sv */
/*
  shared constants, types and helpers for the two-wire eeprom read engine.
  assumes a 256 x 8 array, 8-byte pages and three chip select straps.
*/
package eeprom_rd_pkg;
  // ****************************************************************
  // memory organisation
  // ****************************************************************
  localparam int          ADDR_W     = 8;       // word address width
  localparam int          MEM_DEPTH  = 256;     // bytes in the array
  localparam int          PAGE_W     = 3;       // 8-byte page
  localparam int          SEL_W      = 3;       // chip select straps
  localparam logic [3:0]  DEV_PREFIX = 4'hA;    // fixed address prefix
  localparam logic [3:0]  BYTE_BITS  = 4'h8;    // data bits per byte
  // ****************************************************************
  // host timing
  // ****************************************************************
  localparam int          CORE_CLK_NS   = 50;   // 20 MHz core clock
  localparam int          SCL_PERIOD_NS = 2500; // 400 kHz bus clock
  // one quarter of the bus clock, rounded up to whole core cycles
  localparam logic [3:0]  QTR_CYC = 4'((SCL_PERIOD_NS / 4 + CORE_CLK_NS - 1) / CORE_CLK_NS);
  // ****************************************************************
  // host operations
  // ****************************************************************
  typedef enum logic [1:0] {
    OP_CUR_READ,                                // read at counter
    OP_RAND_READ,                               // dummy write, then read
    OP_BYTE_WRITE                               // single byte write
  } op_t;

  // device address byte: prefix, straps, direction bit
  function automatic logic [7:0] dev_byte(input logic [SEL_W-1:0] sel, input logic rd);
    return {DEV_PREFIX, sel, rd};
  endfunction : dev_byte
endpackage : eeprom_rd_pkg

/* File: testbench/eeprom_link_checker.sv */
/*
  checker of the two-wire link between the host end and the eeprom end.
  assumes the link clock oversamples scl and sda and the line has a pull-up.
*/
`timescale 1ns/10ps
module eeprom_link_checker (
  input  wire logic       LINK_CLK_I,   // link clock
  input  wire logic       SYS_RST_I,    // async reset, high
  input  wire logic       scl,          // bus clock
  input  wire logic       host_sda_o,   // host data out
  input  wire logic       host_sda_oe,  // host pulls low
  input  wire logic       dev_sda_o,    // device data out
  input  wire logic       dev_sda_oe,   // device pulls low
  input  wire logic       sda           // resolved line
);
  default clocking @(posedge LINK_CLK_I); endclocking
  default disable iff (SYS_RST_I);
  logic [9:0] hold_q;  // link cycles the device has held the line low
  // run length of a device pull; a stuck driver would lock the bus
  always_ff @(posedge LINK_CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      hold_q <= 10'h000;
    end else begin
      hold_q <= dev_sda_oe ? hold_q + 10'h001 : 10'h000;
    end
  end
  sequence start_s; scl && $past(scl) && $fell(sda); endsequence
  sequence stop_s; scl && $past(scl) && $rose(sda); endsequence
  take_low_a: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device took the line with scl high");
  let_go_a: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("device released the line with scl high");
  steady_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device data moved while scl high");
  wired_level_a: assert property (sda == !(host_sda_oe || dev_sda_oe))
    else $error("line level does not follow the pulls");
  open_drain_a: assert property (!dev_sda_o && !host_sda_o)
    else $error("driver data is not low");
  stop_idle_a: assert property (stop_s |=> !dev_sda_oe [*8])
    else $error("device pulls after stop");
  start_quiet_a: assert property (start_s |=> !dev_sda_oe [*8])
    else $error("device pulls during address byte");
  hold_bound_a: assert property (hold_q < 10'h320)
    else $error("device held the line too long");
  cover property (start_s ##[1:1000] $rose(dev_sda_oe));
  cover property (stop_s);
  cover property (hold_q == 10'h12C);
endmodule : eeprom_link_checker

/* File: testbench/test_serial_eeprom_read_engine.sv */
/*
  bench joining the host end and the eeprom end over the link interface.
  assumes the host paces the bus from the core clock; no partner model.
*/
`timescale 1ns/10ps
module test_serial_eeprom_read_engine;
  localparam eeprom_rd_pkg::op_t CR = eeprom_rd_pkg::OP_CUR_READ;   // current read
  localparam eeprom_rd_pkg::op_t RR = eeprom_rd_pkg::OP_RAND_READ;  // random read
  localparam eeprom_rd_pkg::op_t BW = eeprom_rd_pkg::OP_BYTE_WRITE; // byte write
  typedef struct packed {
    eeprom_rd_pkg::op_t o;  // operation
    logic [2:0]         s;  // select
    logic [7:0]         a;  // address
    logic [7:0]         d;  // write data
    logic [7:0]         n;  // read length
  } row_t;
  logic               clk = 1'b0, lclk = 1'b0, rst = 1'b1;  // clocks, reset
  logic               valid = 1'b0;                         // request offered
  eeprom_rd_pkg::op_t op = CR;                              // operation
  logic [2:0]         sel = 3'h2, straps = 3'h2;            // select, straps
  logic [7:0]         addr = 8'h00, wdata = 8'h00, len = 8'h00; // fields
  logic               ready, rd_valid, done, nack, active;  // flags
  logic [7:0]         rd_data, word, cnt = 8'h00;           // data, counters
  logic [7:0]         mem [256];                            // expected array
  logic [8:0]         sh = 9'h000, first = 9'h000;          // wire capture
  logic [7:0]         got [$];                              // bytes received
  int                 nbits = 0, miscompares = 0, checked = 0;
  // w-f8, w-ff wraps page, cur, w 00..02, random ff wraps array, cur len 0, stranger
  row_t rows [9] = '{'{BW, 3'h2, 8'hF8, 8'h11, 8'h00}, '{BW, 3'h2, 8'hFF, 8'h22, 8'h00},
    '{CR, 3'h2, 8'h00, 8'h00, 8'h01}, '{BW, 3'h2, 8'h00, 8'h33, 8'h00}, '{BW, 3'h2, 8'h01, 8'h44, 8'h00},
    '{BW, 3'h2, 8'h02, 8'h55, 8'h00}, '{RR, 3'h2, 8'hFF, 8'h00, 8'h03}, '{CR, 3'h2, 8'h00, 8'h00, 8'h00},
    '{RR, 3'h5, 8'h10, 8'h00, 8'h01}};
  eeprom_link_if link ();
  always #25 clk = ~clk;
  initial #3 forever #16 lclk = ~lclk;  // unrelated phase
  eeprom_rd_host u_eeprom_rd_host (.CORE_CLK_I(clk), .SYS_RST_I(rst), .link(link.host), .REQ_VALID_I(valid),
    .REQ_READY_O(ready), .REQ_OP_I(op), .REQ_SEL_I(sel), .REQ_ADDR_I(addr), .REQ_WDATA_I(wdata),
    .REQ_LEN_I(len), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .DONE_O(done), .NACK_O(nack));
  eeprom_rd_device u_eeprom_rd_device (.LINK_CLK_I(lclk), .SYS_RST_I(rst), .link(link.device),
    .CHIP_SELECT_PIN_HIGH_I(straps[2]), .CHIP_SELECT_PIN_MID_I(straps[1]),
    .CHIP_SELECT_PIN_LOW_I(straps[0]), .DEV_ACTIVE_O(active), .DEV_WORD_ADDR_O(word));
  eeprom_link_checker u_eeprom_link_checker (.LINK_CLK_I(lclk), .SYS_RST_I(rst), .scl(link.scl),
    .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .sda(link.sda));
  // ********************
  // wire watch: a start restarts framing, bits shift in on scl rise
  // ********************
  always @(negedge link.sda) if (link.scl === 1'b1) nbits = 0;
  always @(posedge link.scl) begin
    sh = {sh[7:0], link.sda};
    nbits++;
    if (nbits == 9) first = sh;  // last address byte plus its ack slot
  end
  // sampled off the edge so the pulse has settled
  always @(negedge clk) if (rd_valid === 1'b1) got.push_back(rd_data);
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  // one request, bounded wait for done, then the model's view
  task automatic run(input eeprom_rd_pkg::op_t o, input logic [2:0] s, input logic [7:0] a, d, n);
    int  i;
    int  k;
    logic miss;
    logic seen;
    got.delete();
    seen = 1'b0;
    @(posedge clk);
    valid <= 1'b1;
    op <= o;
    sel <= s;
    addr <= a;
    wdata <= d;
    len <= n;
    @(posedge clk);
    valid <= 1'b0;
    for (i = 0; i < 9000 && done !== 1'b1; i++) begin
      @(negedge clk);
      seen = seen | (active & ~ready);  // both ends busy at once
    end
    if (i == 9000) begin
      miscompares++;
      end_of_test();
    end
    miss = (s !== straps);
    k = (n == 8'h00) ? 1 : int'(n);
    // last address byte: a refused dummy write never reaches the read address
    chk(first, {eeprom_rd_pkg::DEV_PREFIX, s, (o == CR) || (o == RR && !miss), miss});
    chk({8'h00, nack}, {8'h00, miss});
    chk({8'h00, seen}, 9'h001);
    if (!miss) begin
      if (o == RR) cnt = a;
      if (o == BW) begin
        mem[a] = d;
        cnt = {a[7:3], a[2:0] + 3'h1};  // wraps inside the page
      end else begin
        for (i = 0; i < k; i++) begin
          chk({1'b0, got[i]}, {1'b0, mem[cnt]});
          cnt = cnt + 8'h01;  // wraps from the top to zero
        end
      end
    end
    chk({1'b0, word}, {1'b0, cnt});
    chk({6'h00, link.scl, link.sda, active}, 9'h006);
  endtask : run
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    foreach (rows[r]) begin
      run(rows[r].o, rows[r].s, rows[r].a, rows[r].d, rows[r].n);
      $display("row %0d finished", r);
    end
    @(posedge clk);
    straps <= 3'h5;  // new straps, old select no longer matches
    repeat (10) @(posedge clk);
    run(RR, 3'h5, 8'h01, 8'h00, 8'h02);
    run(CR, 3'h2, 8'h00, 8'h00, 8'h01);
    $display("strap test finished");
    @(posedge clk);
    valid <= 1'b1;  // long read request, reset lands in its address byte
    op <= CR;
    sel <= 3'h5;
    len <= 8'h14;
    @(posedge clk);
    valid <= 1'b0;
    repeat (300) @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
    cnt = 8'h00;
    chk({1'b0, word}, 9'h000);
    chk({6'h00, link.scl, link.sda, ready}, 9'h007);
    run(BW, 3'h5, 8'h07, 8'h66, 8'h00);
    run(RR, 3'h5, 8'h07, 8'h00, 8'h01);
    $display("reset test finished");
    end_of_test();
  end
endmodule : test_serial_eeprom_read_engine
